// >>> rtl/gcc_counter.v
// 16-bit gated up-counter with its control, byte and status registers.
// assumes a single core_clk; pins arrive unsynchronised from outside.
// Function
// (RULE_01) one 8-bit control register, fixed bit layout
// (RULE_02) run clear: gate ignored, counter holds
// (RULE_03) run and gate enable: count while permitted
// (RULE_04) gate enable needed; source pin or comparator
// (RULE_05) oscillator enable bit switches crystal oscillator
// (RULE_06) count readable/writable as two byte registers
// (RULE_07) gate invert reverses selected gate polarity
// (RULE_08) sync bit set: external clock unsynchronised
// (RULE_09) source 0 instruction clock, 1 external pin
// (RULE_10) rollover to zero sets overflow flag
// (RULE_11) prescale divides by 1, 2, 4, 8
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "gcc_consts.vh"
module gcc_counter (
  input  wire                  core_clk,              // 125 MHz system clock
  input  wire                  resetn,                // async reset, active low
  input  wire [`GCC_ADDR_W-1:0] reg_addr,             // register address
  input  wire [7:0]            reg_wdata,             // write data
  input  wire                  reg_wr,                // write strobe
  input  wire                  reg_rd,                // read strobe
  output reg  [7:0]            reg_rdata,             // read data, cycle after strobe
  input  wire                  external_clock_pin,    // external count clock
  input  wire                  low_power_crystal_osc, // crystal oscillator output
  input  wire                  gate_pin,              // gate input pin
  input  wire                  comparator_two_output, // comparator gate source
  output wire                  crystal_osc_enable,    // turns the crystal oscillator on
  output wire                  overflow_flag          // sticky rollover flag
);
  reg  [7:0]  control_r;
  reg  [7:0]  cmp_control_r;
  reg         ovf_r;
  reg  [15:0] count_r;
  reg  [1:0]  iclk_cnt_r;
  reg         ext_prev_r;
  reg         ext_armed_r;
  reg         ext_pend_r;
  reg  [2:0]  ps_cnt_r;
  wire [3:0]  pin_sync;
  wire        iclk_en;
  wire        ext_lvl;
  wire        ext_rise;
  wire        src_tick;
  wire        gate_sel;
  wire        gate_ok;
  wire        count_en;
  wire [2:0]  ps_limit;
  wire        ps_tick;
  wire        wr_low;
  wire        wr_high;
  wire        inc;
  wire        rollover;
  wire        wr_control;
  wire        wr_cmp_control;
  wire        clr_ovf;
  reg  [7:0]  rdata_nxt;

  // every pin crosses in here before any logic looks at it; the crystal and the
  // external pin are synchronised apart so the source mux never sees a raw level
  gcc_sync2 #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in ({comparator_two_output, gate_pin, low_power_crystal_osc, external_clock_pin}),
    .sync_out (pin_sync)
  );

  assign crystal_osc_enable = control_r[`GCC_BIT_XOSC_EN]; // RULE_05
  assign overflow_flag      = ovf_r;

  // instruction clock enable: system clock divided by four
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      iclk_cnt_r <= 2'h0;
    else
      iclk_cnt_r <= iclk_cnt_r + 2'h1;
  end
  assign iclk_en = (iclk_cnt_r == `GCC_ICLK_LAST);

  // a switched-off crystal stands low, so selecting it gives no stray rise
  assign ext_lvl  = control_r[`GCC_BIT_XOSC_EN] ? pin_sync[1] : pin_sync[0];       // RULE_05
  // a falling edge (low level) must be seen before the first counted rise
  assign ext_rise = ext_lvl && !ext_prev_r && ext_armed_r;

  // ext_prev_r resets low, matching an idle low pin; arming hides a false edge anyway
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ext_prev_r <= 1'b0;
    else
      ext_prev_r <= ext_lvl;
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ext_armed_r <= 1'b0;
    else if (!control_r[`GCC_BIT_RUN])
      ext_armed_r <= 1'b0;
    else if (!ext_lvl)
      ext_armed_r <= 1'b1;
  end

  // synchronised mode holds the edge until the next instruction clock; an edge
  // that meets the instruction clock is counted at once, so the pend is dropped
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ext_pend_r <= 1'b0;
    else if (iclk_en)
      ext_pend_r <= 1'b0;
    else if (ext_rise)
      ext_pend_r <= 1'b1;
  end

  // the bypass path still passes the pin synchroniser: one clock cannot count
  // a truly asynchronous edge, so it only skips the instruction-clock alignment
  assign src_tick = !control_r[`GCC_BIT_CLK_SRC] ? iclk_en :                          // RULE_09
                    control_r[`GCC_BIT_SYNC_BYP] ? ext_rise :                         // RULE_08
                    (iclk_en && (ext_pend_r || ext_rise));                            // RULE_08

  // the gate is seen two cycles late through the synchroniser
  assign gate_sel = cmp_control_r[`GCC_BIT_GATE_SRC] ? pin_sync[3] : pin_sync[2];    // RULE_04
  // invert=1 counts while gate is high, invert=0 while it is low
  assign gate_ok  = (gate_sel == control_r[`GCC_BIT_GATE_INV]);                       // RULE_07
  assign count_en = control_r[`GCC_BIT_RUN] &&                                        // RULE_02
                    (!control_r[`GCC_BIT_GATE_EN] || gate_ok);                        // RULE_03

  // limit 0, 1, 3 or 7; the 3-bit shift wraps code 3 to zero before the subtraction
  assign ps_limit = (3'h1 << control_r[`GCC_BIT_PS_HI:`GCC_BIT_PS_LO]) - 3'h1;        // RULE_11
  assign ps_tick  = count_en && src_tick && (ps_cnt_r >= ps_limit);                   // RULE_11

  assign wr_low   = reg_wr && (reg_addr == `GCC_OFS_COUNT_LOW);
  assign wr_high  = reg_wr && (reg_addr == `GCC_OFS_COUNT_HIGH);
  assign inc      = ps_tick && !wr_low && !wr_high;
  assign rollover = inc && (count_r == 16'hffff);
  assign wr_control     = reg_wr && (reg_addr == `GCC_OFS_CONTROL);
  assign wr_cmp_control = reg_wr && (reg_addr == `GCC_OFS_CMP_CONTROL);
  assign clr_ovf        = reg_wr && (reg_addr == `GCC_OFS_STATUS) && reg_wdata[`GCC_BIT_OVF];

  // prescaler clears on any write to the count bytes
  // and holds while counting is off, so a gated pause resumes mid-divide
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ps_cnt_r <= 3'h0;
    else if (wr_low || wr_high)
      ps_cnt_r <= 3'h0;
    else if (ps_tick)
      ps_cnt_r <= 3'h0;
    else if (count_en && src_tick && ps_cnt_r != `GCC_PS_MAX)
      ps_cnt_r <= ps_cnt_r + 3'h1;
  end

  // count has no reset: its value is undefined after power-on
  always @(posedge core_clk)
  begin
    if (wr_low)
      count_r[7:0] <= reg_wdata;                 // RULE_06
    else if (inc)
      count_r[7:0] <= count_r[7:0] + 8'h01;
    if (wr_high)
      count_r[15:8] <= reg_wdata;                // RULE_06
    else if (inc && count_r[7:0] == 8'hff)
      count_r[15:8] <= count_r[15:8] + 8'h01;
  end

  // control resets to zero on every reset, unlike the count bytes
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      control_r <= `GCC_CONTROL_RST;
    else if (wr_control)
      control_r <= reg_wdata;                    // RULE_01
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cmp_control_r <= `GCC_CMP_CONTROL_RST;
    else if (wr_cmp_control)
      cmp_control_r <= reg_wdata;                // RULE_04
  end

  // a rollover in the clearing cycle keeps the flag set, so software that
  // clears late never loses an overflow
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ovf_r <= 1'b0;
    else if (rollover)
      ovf_r <= 1'b1;                             // RULE_10
    else if (clr_ovf)
      ovf_r <= 1'b0;
  end

  // read mux; unmapped offsets and idle cycles give zero
  always @*
  begin
    rdata_nxt = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `GCC_OFS_CONTROL:     rdata_nxt = control_r;                  // RULE_01
        `GCC_OFS_COUNT_LOW:   rdata_nxt = count_r[7:0];               // RULE_06
        `GCC_OFS_COUNT_HIGH:  rdata_nxt = count_r[15:8];              // RULE_06
        `GCC_OFS_CMP_CONTROL: rdata_nxt = cmp_control_r;
        `GCC_OFS_STATUS:      rdata_nxt = {7'h00, ovf_r};             // RULE_10
        default:              rdata_nxt = 8'h00;
      endcase
    end
  end

  // read data stand for exactly one cycle after the strobe
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rdata_nxt;
  end
endmodule // gcc_counter

// >>> rtl/gcc_consts.vh
// constants for the gated counter control block: register offsets,
// control field positions, reset values and clock-divider counts.
// assumes it is included by bare name from the rtl/ design files.
`ifndef GCC_CONSTS_VH
`define GCC_CONSTS_VH

`define GCC_ADDR_W          3
`define GCC_OFS_CONTROL     3'h0
`define GCC_OFS_COUNT_LOW   3'h1
`define GCC_OFS_COUNT_HIGH  3'h2
`define GCC_OFS_CMP_CONTROL 3'h3
`define GCC_OFS_STATUS      3'h4

`define GCC_BIT_GATE_INV    7
`define GCC_BIT_GATE_EN     6
`define GCC_BIT_PS_HI       5
`define GCC_BIT_PS_LO       4
`define GCC_BIT_XOSC_EN     3
`define GCC_BIT_SYNC_BYP    2
`define GCC_BIT_CLK_SRC     1
`define GCC_BIT_RUN         0

`define GCC_BIT_GATE_SRC    1
`define GCC_BIT_OVF         0

`define GCC_CONTROL_RST     8'h00
`define GCC_CMP_CONTROL_RST 8'h00

// instruction clock is the system clock divided by four: enable on the last count
`define GCC_ICLK_LAST       2'h3
`define GCC_PS_MAX          3'h7

`endif

// >>> rtl/gcc_sync2.v
// two-flop synchroniser for pins and other-domain levels.
// assumes core_clk samples inputs that may change at any time.
`timescale 1ns/1ps
module gcc_sync2 #(
  parameter W = 1
) (
  input  wire         core_clk, // system clock
  input  wire         resetn,   // async reset, active low
  input  wire [W-1:0] async_in, // level from outside the domain
  output wire [W-1:0] sync_out  // level safe for logic
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // meta_r is read by sync_r alone
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // gcc_sync2

// >>> sim/gcc_counter_chk.sv
// checker: register-port and flag relations of gcc_counter
// assumes it sees only the top-level ports
`timescale 1ns/1ps
module gcc_counter_chk (
  input logic       core_clk,           // clock
  input logic       resetn,             // reset, active low
  input logic [2:0] reg_addr,           // address
  input logic [7:0] reg_wdata,          // write data
  input logic       reg_wr,             // write strobe
  input logic       reg_rd,             // read strobe
  input logic [7:0] reg_rdata,          // read data
  input logic       crystal_osc_enable, // oscillator on
  input logic       overflow_flag       // rollover flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence ctl_wr; reg_wr && reg_addr == 3'h0; endsequence
  sequence ctl_rd; reg_rd && reg_addr == 3'h0; endsequence
  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  ctl_back_a: assert property (ctl_wr ##1 !reg_wr ##1 ctl_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control readback wrong");
  unmapped_a: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  osc_follow_a: assert property (ctl_wr |=> crystal_osc_enable == $past(reg_wdata[3]))
    else $error("oscillator enable not written");
  osc_hold_a: assert property (!(reg_wr && reg_addr == 3'h0) |=> $stable(crystal_osc_enable))
    else $error("oscillator enable moved");
  osc_read_a: assert property (ctl_rd |=> reg_rdata[3] == crystal_osc_enable)
    else $error("oscillator bit readback wrong");
  ovf_sticky_a: assert property (overflow_flag && !(reg_wr && reg_addr == 3'h4 && reg_wdata[0]) |=> overflow_flag)
    else $error("overflow flag dropped");
  ovf_read_a: assert property (reg_rd && reg_addr == 3'h4 |=> reg_rdata[0] == $past(overflow_flag))
    else $error("status readback wrong");
endmodule // gcc_counter_chk
bind gcc_counter gcc_counter_chk u_chk (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .crystal_osc_enable(crystal_osc_enable), .overflow_flag(overflow_flag));

// >>> sim/gcc_far_model.sv
// far side: external count clock and crystal oscillator
// assumes the bench frames ext_run; the external clock stands low outside frames, the crystal while disabled
`timescale 1ns/1ps
module gcc_far_model (
  input  logic ext_run,               // frame of external pulses
  input  logic crystal_osc_enable,    // oscillator switched on
  output logic external_clock_pin,    // external clock, 16 core cycles
  output logic low_power_crystal_osc  // crystal, 8 core cycles
);
  initial external_clock_pin = 1'b0;
  initial low_power_crystal_osc = 1'b0;
  always #64 external_clock_pin = ext_run ? ~external_clock_pin : 1'b0;
  // a stopped oscillator falls low and gives no further edges
  always #32 low_power_crystal_osc = crystal_osc_enable ? ~low_power_crystal_osc : 1'b0;
endmodule // gcc_far_model

// >>> sim/testbench.sv
// bench: drives gcc_counter through its register port, checks counts
// assumes gcc_far_model supplies the external and crystal clocks
`timescale 1ns/1ps
module testbench;
  logic       core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       gate_pin = 1'b0, comparator_two_output = 1'b0, ext_run = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, v;
  wire  [7:0] reg_rdata;
  wire        external_clock_pin, low_power_crystal_osc, crystal_osc_enable, overflow_flag;
  int         mismatches = 0, tests_run = 0, cycles = 0;
  always #4 core_clk = ~core_clk;
  gcc_counter dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_clock_pin(external_clock_pin),
    .low_power_crystal_osc(low_power_crystal_osc), .gate_pin(gate_pin),
    .comparator_two_output(comparator_two_output), .crystal_osc_enable(crystal_osc_enable),
    .overflow_flag(overflow_flag));
  gcc_far_model far (.ext_run(ext_run), .crystal_osc_enable(crystal_osc_enable),
    .external_clock_pin(external_clock_pin), .low_power_crystal_osc(low_power_crystal_osc));
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    begin
      tests_run++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
        mismatches++;
        $display("CHECK FAILED at %0t: byte %h not in %h..%h", $time, got, lo, hi);
      end
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    begin
      tests_run++;
      if (got !== exp)
      begin
        mismatches++;
        $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
      end
    end
  endtask
  // a gap cycle after each strobe keeps the next task off this edge
  task wr(input logic [2:0] a, input logic [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input logic [2:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      v = reg_rdata;
    end
  endtask
  // counting window of about 258 cycles; instruction-clock phase is free, so allow slack
  task meas(input logic [7:0] ctl, input logic [7:0] e);
    begin
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h0, ctl);
      repeat (256) @(posedge core_clk);
      wr(3'h0, 8'h00);
      rd(3'h1);
      chk(v, (e == 0) ? e : e - 8'd1, (e == 0) ? e : e + 8'd2);
    end
  endtask
  task gate(input logic [7:0] ctl, input logic [7:0] cmp, input logic g, input logic c, input logic [7:0] e);
    begin
      wr(3'h3, cmp);
      gate_pin <= g;
      comparator_two_output <= c;
      meas(ctl, e);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(3'h0);
    chk(v, 8'h00, 8'h00);
    wr(3'h0, 8'ha4);
    rd(3'h0);
    chk(v, 8'ha4, 8'ha4);
    wr(3'h0, 8'h08);
    chk_bit(crystal_osc_enable, 1'b1);
    rd(3'h0);
    wr(3'h0, 8'h00);
    chk_bit(crystal_osc_enable, 1'b0);
    wr(3'h1, 8'h5a);
    wr(3'h2, 8'hc3);
    rd(3'h1);
    chk(v, 8'h5a, 8'h5a);
    rd(3'h2);
    chk(v, 8'hc3, 8'hc3);
    rd(3'h7);
    chk(v, 8'h00, 8'h00);
    $display("register test done");
    wr(3'h0, 8'ha4);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(3'h0);
    chk(v, 8'h00, 8'h00);
    rd(3'h1);
    chk(v, 8'h5a, 8'h5a);
    rd(3'h2);
    chk(v, 8'hc3, 8'hc3);
    $display("reset test done");
    for (int p = 0; p < 4; p++)
      meas({2'b00, p[1:0], 4'h1}, 8'd64 >> p);
    $display("prescale test done");
    gate(8'h40, 8'h00, 1'b0, 1'b0, 8'd0);
    gate(8'h41, 8'h00, 1'b1, 1'b0, 8'd0);
    gate(8'h41, 8'h00, 1'b0, 1'b1, 8'd64);
    gate(8'h01, 8'h00, 1'b1, 1'b1, 8'd64);
    gate(8'hc1, 8'h00, 1'b1, 1'b0, 8'd64);
    gate(8'h41, 8'h02, 1'b1, 1'b0, 8'd64);
    gate(8'hc1, 8'h02, 1'b1, 1'b0, 8'd0);
    wr(3'h3, 8'h00);
    $display("gate test done");
    ext_run <= 1'b1;
    meas(8'h03, 8'd16);
    meas(8'h07, 8'd16);
    meas(8'h0b, 8'd32);
    ext_run <= 1'b0;
    $display("external clock test done");
    wr(3'h1, 8'hfe);
    wr(3'h2, 8'hff);
    chk_bit(overflow_flag, 1'b0);
    wr(3'h0, 8'h01);
    repeat (16) @(posedge core_clk);
    chk_bit(overflow_flag, 1'b1);
    rd(3'h4);
    chk_bit(v[0], 1'b1);
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h01);
    chk_bit(overflow_flag, 1'b0);
    $display("overflow test done");
    complete_run;
  end
endmodule // testbench
